// [design/dual_mac_pkg.sv]
// shared constants and types of the dual multiply datapath
package dual_mac_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int ACC_W = 40;
  localparam int EXT_W = 17;
  localparam int NUM_ACC = 4;
  localparam int ACC_IDX_W = 2;
  localparam int RPT_W = 16;
  localparam int OPC_W = 32;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam int BUS_BE = 4;
  localparam int BYTE_W = 8;
  // ==========================================================
  // instruction word fields
  localparam logic [7:0] OPC_FIRST = 8'hfd;
  localparam logic [3:0] OPC_SHARED = 4'h0;
  localparam logic [3:0] OPC_LONG = 4'h4;
  localparam int OPC_FIRST_MSB = 31;
  localparam int OPC_FIRST_LSB = 24;
  localparam int OPC_ADDR_MSB = 23;
  localparam int OPC_ADDR_LSB = 17;
  localparam int OPC_DMODE_MSB = 18;
  localparam int OPC_DMODE_LSB = 17;
  localparam int OPC_IND_BIT = 16;
  localparam int OPC_VAR_MSB = 15;
  localparam int OPC_VAR_LSB = 12;
  localparam int OPC_PAD_MSB = 11;
  localparam int OPC_PAD_LSB = 10;
  localparam int OPC_CMODE_MSB = 9;
  localparam int OPC_CMODE_LSB = 8;
  localparam int OPC_OPT_MSB = 7;
  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;
  localparam logic [ADDR_W-1:0] STEP_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_PAIR = 16'h0002;
  localparam logic [ADDR_W-1:0] PAIR_FLIP = 16'h0001;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [BUS_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [BUS_AW-1:0] OPCODE_OFS = 8'h04;
  localparam logic [BUS_AW-1:0] REPEAT_OFS = 8'h08;
  localparam logic [BUS_AW-1:0] STATUS_OFS = 8'h0c;
  localparam logic [BUS_AW-1:0] DPTR_OFS = 8'h10;
  localparam logic [BUS_AW-1:0] CPTR_OFS = 8'h14;
  localparam logic [2:0] ACC_REGION = 3'h1;
  localparam int ACC_REGION_MSB = 7;
  localparam int ACC_REGION_LSB = 5;
  localparam int ACC_IDX_MSB = 4;
  localparam int ACC_IDX_LSB = 3;
  localparam int ACC_HI_BIT = 2;
  // ==========================================================
  // arithmetic constants
  localparam logic [EXT_W-1:0] OPND_MIN = 17'h18000;
  localparam logic [ACC_W-1:0] PROD_SAT = 40'h007fffffff;
  localparam logic [ACC_W:0] RND_ADD = 41'h00000008000;
  localparam logic [15:0] RND_HALF = 16'h8000;
  localparam int RND_LSB = 16;
  localparam int SIGN32_LSB = 31;
  localparam logic [ACC_W-1:0] SAT_POS_32 = 40'h007fffffff;
  localparam logic [ACC_W-1:0] SAT_NEG_32 = 40'hff80000000;
  localparam logic [ACC_W-1:0] SAT_POS_40 = 40'h7fffffffff;
  localparam logic [ACC_W-1:0] SAT_NEG_40 = 40'h8000000000;
  // ==========================================================
  // types
  typedef struct packed {
    logic sign_extension_mode; logic saturation_mode; logic rounding_mode; logic m40; logic multiply_saturation_mode; logic fractional_mode;
  } mode_s;
  localparam int MODE_W = 6;
  localparam mode_s MODE_RESET = 6'h20;
  typedef struct packed {
    logic [ACC_IDX_W-1:0] acc_x; logic [ACC_IDX_W-1:0] acc_y;
    logic uns_data; logic uns_coef; logic forty; logic rnd;
  } opt_s;
  typedef struct packed {
    logic [NUM_ACC-1:0] ovf; logic [1:0] pad; logic illegal; logic busy;
  } status_s;
  localparam int STATUS_W = 8;
  typedef struct packed {
    logic [ADDR_W-1:0] data_addr; logic [ADDR_W-1:0] data_pair_addr;
    logic data_rd; logic data_pair_rd;
    logic [ADDR_W-1:0] coef_addr; logic [ADDR_W-1:0] coef_pair_addr;
    logic coef_rd;
  } mem_req_s;
  typedef struct packed {
    logic [DATA_W-1:0] d_read_bus; logic [DATA_W-1:0] c_read_bus;
    logic [DATA_W-1:0] b_read_bus; logic [DATA_W-1:0] b2_read_bus;
  } mem_rsp_s;
endpackage

// [design/mac_unit.sv]
// one multiply unit: widen, multiply, scale, round, overflow, saturate
`timescale 1ns/1ps
`default_nettype none
module mac_unit (
  input wire logic [dual_mac_pkg::DATA_W-1:0] data_in,
  input wire logic [dual_mac_pkg::DATA_W-1:0] coef_in,
  input wire logic uns_data,
  input wire logic uns_coef,
  input wire dual_mac_pkg::mode_s mode,
  input wire logic rnd,
  input wire logic forty,
  output logic [dual_mac_pkg::ACC_W-1:0] result,
  output logic overflow
);
  import dual_mac_pkg::*;

  // zero fill when unsigned or when sign extension mode is off
  function automatic logic [EXT_W-1:0] widen(
    input logic [DATA_W-1:0] v, input logic uns, input logic sign_extension_mode);
    return {~uns & sign_extension_mode & v[DATA_W-1], v}; // RQ9 RQ21
  endfunction

  logic [EXT_W-1:0] op_a;
  logic [EXT_W-1:0] op_b;
  logic signed [2*EXT_W-1:0] prod;
  logic [ACC_W-1:0] ext;
  logic [ACC_W-1:0] scaled;
  logic [ACC_W:0] sum;
  logic [ACC_W-1:0] rounded;
  logic m40_eff;
  logic ovf32;
  logic ovf40;
  logic neg;

  always_comb begin
    op_a = widen(data_in, uns_data, mode.sign_extension_mode);
    op_b = widen(coef_in, uns_coef, mode.sign_extension_mode);
    prod = $signed(op_a) * $signed(op_b);
    ext = {{(ACC_W-2*EXT_W){prod[2*EXT_W-1]}}, prod}; // RQ12
    scaled = mode.fractional_mode ? {ext[ACC_W-2:0], 1'b0} : ext; // RQ10
    // with signed operands only (-1)*(-1) in fractional mode can leave the signed range
    if (mode.fractional_mode && mode.multiply_saturation_mode && op_a == OPND_MIN && op_b == OPND_MIN) begin
      scaled = PROD_SAT; // RQ11
    end
    sum = {scaled[ACC_W-1], scaled};
    if (rnd) begin
      sum = sum + RND_ADD; // RQ13
      sum[RND_LSB-1:0] = '0;
      if (mode.rounding_mode && scaled[RND_LSB-1:0] == RND_HALF) begin
        sum[RND_LSB] = 1'b0; // RQ13
      end
    end
    rounded = sum[ACC_W-1:0];
    m40_eff = mode.m40 | forty; // RQ16
    ovf40 = sum[ACC_W] ^ sum[ACC_W-1];
    ovf32 = ~(&rounded[ACC_W-1:SIGN32_LSB]) & (|rounded[ACC_W-1:SIGN32_LSB]);
    overflow = m40_eff ? ovf40 : ovf32; // RQ14
    neg = m40_eff ? sum[ACC_W] : rounded[ACC_W-1];
    result = rounded;
    if (overflow && mode.saturation_mode) begin
      if (m40_eff) begin
        result = neg ? SAT_NEG_40 : SAT_POS_40; // RQ15
      end else begin
        result = neg ? SAT_NEG_32 : SAT_POS_32; // RQ15
      end
    end
  end
endmodule
`default_nettype wire

// [design/dual_mac_core.sv]
// dual multiply datapath with avalon-mm register access
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Functional notes
// RQ1 - both products are computed and written in one execute cycle
// RQ2 - shared-operand form: first byte fd, third byte upper nibble 0000
// RQ3 - long-data form: same word but third byte upper nibble 0100
// RQ4 - shared form reads one data word on d bus for both units
// RQ5 - high coefficient at ea via b2 bus into second unit, to acy
// RQ6 - low halves at ea xor 1; low coefficient via b bus to acx
// RQ7 - long form high data at ea on c bus into second unit
// RQ8 - long form low data at partner address on d bus, first unit
// RQ9 - operands widen to 17 bits, zero fill when unsigned
// RQ10 - fractional mode doubles each product
// RQ11 - multiply saturation mode clamps the minus-one squared case
// RQ12 - product sign extends to 40 bits
// RQ13 - optional rounding, biased or unbiased by rounding mode
// RQ14 - overflow at 32 or 40 bits sets the accumulator flag
// RQ15 - saturation mode clamps an overflowed accumulator
// RQ16 - forty keyword forces 40-bit mode for one instruction only
// RQ17 - software keeps coefficients in internal memory only
// RQ18 - the instruction may be repeated by a repeat count
// RQ19 - pointers on long pairs step by two
// RQ20 - single data pointer post-decrement steps by one
// RQ21 - without unsigned, sign extension follows sign extension mode
// RQ22 - both accumulators and flags update in the same cycle
module dual_mac_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [dual_mac_pkg::BUS_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [dual_mac_pkg::BUS_DW-1:0] writedata,
  input wire logic [dual_mac_pkg::BUS_BE-1:0] byteenable,
  output logic [dual_mac_pkg::BUS_DW-1:0] readdata,
  output logic waitrequest,
  output dual_mac_pkg::mem_req_s mem_req,
  input wire dual_mac_pkg::mem_rsp_s mem_rsp
);
  import dual_mac_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_FETCH, ST_EXEC} state_e;

  state_e state_reg;
  mode_s mode_reg;
  logic [OPC_W-1:0] op_reg;
  logic [RPT_W-1:0] rpt_reg;
  logic [RPT_W-1:0] rpt_left_reg;
  logic illegal_reg;
  logic [ADDR_W-1:0] dptr_reg;
  logic [ADDR_W-1:0] cptr_reg;
  mem_req_s mem_req_reg;
  logic [BUS_DW-1:0] readdata_reg;
  logic waitrequest_reg;
  logic [NUM_ACC-1:0] ovf_flags;
  logic [ACC_W-1:0] acc_val [NUM_ACC];

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign mem_req = mem_req_reg;

  // ==========================================================
  // decode of the held instruction word
  opt_s opt;
  logic long_mode;
  logic indirect;
  logic [1:0] dmode;
  logic [1:0] cmode;
  logic [ADDR_W-1:0] data_ea;

  always_comb begin
    long_mode = op_reg[OPC_VAR_MSB:OPC_VAR_LSB] == OPC_LONG; // RQ3
    indirect = op_reg[OPC_IND_BIT];
    dmode = op_reg[OPC_DMODE_MSB:OPC_DMODE_LSB];
    cmode = op_reg[OPC_CMODE_MSB:OPC_CMODE_LSB];
    opt = opt_s'(op_reg[OPC_OPT_MSB:0]);
    data_ea = indirect ? dptr_reg
                       : ADDR_W'(op_reg[OPC_ADDR_MSB:OPC_ADDR_LSB]);
  end

  // ==========================================================
  // avalon-mm slave
  logic busy;
  logic exec;
  logic bus_req;
  logic bus_ok;
  logic wr_fire;
  logic acc_region;
  logic [ACC_IDX_W-1:0] acc_sel;
  logic [BUS_DW-1:0] rd_value;
  logic [BUS_DW-1:0] be_mask;
  logic [BUS_DW-1:0] wr_value;
  status_s status_rd;
  status_s status_wr;

  assign busy = state_reg != ST_IDLE;
  assign exec = state_reg == ST_EXEC;
  assign bus_req = read | write;
  // writes wait while an instruction runs so operands cannot shift under it
  assign bus_ok = read | (write & ~busy);
  assign wr_fire = write & ~waitrequest_reg;
  assign acc_region =
    address[ACC_REGION_MSB:ACC_REGION_LSB] == ACC_REGION;
  assign acc_sel = address[ACC_IDX_MSB:ACC_IDX_LSB];
  assign status_wr = status_s'(wr_value[STATUS_W-1:0]);

  always_comb begin
    status_rd = '0;
    status_rd.ovf = ovf_flags;
    status_rd.illegal = illegal_reg;
    status_rd.busy = busy;
    rd_value = '0;
    case (address)
      CTRL_OFS: rd_value = BUS_DW'(mode_reg);
      OPCODE_OFS: rd_value = op_reg;
      REPEAT_OFS: rd_value = BUS_DW'(rpt_reg);
      STATUS_OFS: rd_value = BUS_DW'(status_rd);
      DPTR_OFS: rd_value = BUS_DW'(dptr_reg);
      CPTR_OFS: rd_value = BUS_DW'(cptr_reg);
      default: begin
        if (acc_region && address[ACC_HI_BIT]) begin
          rd_value = BUS_DW'(acc_val[acc_sel][ACC_W-1:BUS_DW]);
        end else if (acc_region) begin
          rd_value = acc_val[acc_sel][BUS_DW-1:0];
        end
      end
    endcase
    for (int b = 0; b < BUS_BE; b++) begin
      be_mask[b*BYTE_W +: BYTE_W] = {BYTE_W{byteenable[b]}};
    end
    wr_value = (rd_value & ~be_mask) | (writedata & be_mask);
  end

  // one wait cycle per read or idle-time write, answer in the next
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= '0;
    end else if (bus_req && waitrequest_reg && bus_ok) begin
      waitrequest_reg <= 1'b0;
      readdata_reg <= rd_value;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // ==========================================================
  // control registers
  logic legal_op;
  logic start;
  logic exec_more;

  assign legal_op =
    wr_value[OPC_FIRST_MSB:OPC_FIRST_LSB] == OPC_FIRST && // RQ2
    wr_value[OPC_PAD_MSB:OPC_PAD_LSB] == '0 &&
    (wr_value[OPC_VAR_MSB:OPC_VAR_LSB] == OPC_SHARED || // RQ2
     wr_value[OPC_VAR_MSB:OPC_VAR_LSB] == OPC_LONG); // RQ3
  assign start = wr_fire && address == OPCODE_OFS && legal_op;
  assign exec_more = rpt_left_reg != '0;

  // the forty keyword never reaches mode_reg
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET; // RQ16
      rpt_reg <= '0;
      op_reg <= '0;
    end else if (wr_fire) begin
      if (address == CTRL_OFS) begin
        mode_reg <= mode_s'(wr_value[MODE_W-1:0]);
      end
      if (address == REPEAT_OFS) begin
        rpt_reg <= wr_value[RPT_W-1:0];
      end
      if (address == OPCODE_OFS) begin
        op_reg <= wr_value;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      illegal_reg <= 1'b0;
    end else if (wr_fire && address == OPCODE_OFS && !legal_op) begin
      illegal_reg <= 1'b1;
    end else if (wr_fire && address == STATUS_OFS && status_wr.illegal) begin
      illegal_reg <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer: issue, fetch, execute; repeat loops back to issue
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= start ? ST_ISSUE : ST_IDLE;
        ST_ISSUE: state_reg <= ST_FETCH;
        ST_FETCH: state_reg <= ST_EXEC; // RQ1
        ST_EXEC: state_reg <= exec_more ? ST_ISSUE : ST_IDLE; // RQ18
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rpt_left_reg <= '0;
    end else if (start) begin
      rpt_left_reg <= rpt_reg;
    end else if (exec && exec_more) begin
      rpt_left_reg <= rpt_left_reg - RPT_W'(1); // RQ18
    end
  end

  // request stands for the fetch cycle only; data return one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_req_reg <= '0;
    end else if (state_reg == ST_ISSUE) begin
      mem_req_reg.data_addr <= data_ea; // RQ4 RQ7
      mem_req_reg.data_pair_addr <= data_ea ^ PAIR_FLIP; // RQ8
      mem_req_reg.data_rd <= 1'b1;
      mem_req_reg.data_pair_rd <= long_mode; // RQ8
      mem_req_reg.coef_addr <= cptr_reg; // RQ5
      mem_req_reg.coef_pair_addr <= cptr_reg ^ PAIR_FLIP; // RQ6
      mem_req_reg.coef_rd <= 1'b1;
    end else begin
      mem_req_reg <= '0;
    end
  end

  // ==========================================================
  // pointers
  function automatic logic [ADDR_W-1:0] post_mod(
    input logic [ADDR_W-1:0] p, input logic [1:0] m,
    input logic [ADDR_W-1:0] step);
    case (m)
      MODE_INC: return p + step;
      MODE_DEC: return p - step;
      default: return p;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dptr_reg <= '0;
    end else if (exec && indirect) begin
      dptr_reg <= post_mod(dptr_reg, dmode,
                           long_mode ? STEP_PAIR : STEP_ONE); // RQ19 RQ20
    end else if (wr_fire && address == DPTR_OFS) begin
      dptr_reg <= wr_value[ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cptr_reg <= '0;
    end else if (exec) begin
      cptr_reg <= post_mod(cptr_reg, cmode, STEP_PAIR); // RQ19
    end else if (wr_fire && address == CPTR_OFS) begin
      cptr_reg <= wr_value[ADDR_W-1:0];
    end
  end

  // ==========================================================
  // the two multiply units run side by side
  logic [ACC_W-1:0] res_first;
  logic [ACC_W-1:0] res_second;
  logic ovf_first;
  logic ovf_second;
  logic [DATA_W-1:0] second_data;

  assign second_data = long_mode ? mem_rsp.c_read_bus // RQ7
                                 : mem_rsp.d_read_bus; // RQ4

  mac_unit first_multiplier_unit (
    .data_in(mem_rsp.d_read_bus),
    .coef_in(mem_rsp.b_read_bus),
    .uns_data(opt.uns_data),
    .uns_coef(opt.uns_coef),
    .mode(mode_reg),
    .rnd(opt.rnd),
    .forty(opt.forty),
    .result(res_first),
    .overflow(ovf_first)
  );

  mac_unit second_multiplier_unit (
    .data_in(second_data),
    .coef_in(mem_rsp.b2_read_bus),
    .uns_data(opt.uns_data),
    .uns_coef(opt.uns_coef),
    .mode(mode_reg),
    .rnd(opt.rnd),
    .forty(opt.forty),
    .result(res_second),
    .overflow(ovf_second)
  );

  // ==========================================================
  // accumulators and overflow flags
  // if both destinations name one accumulator the second unit wins
  for (genvar i = 0; i < NUM_ACC; i++) begin : g_acc
    logic hit_x;
    logic hit_y;
    logic bus_hit;
    logic [ACC_W-1:0] acc_bit_reg;
    logic ovf_bit_reg;

    assign hit_x = exec && opt.acc_x == ACC_IDX_W'(i);
    assign hit_y = exec && opt.acc_y == ACC_IDX_W'(i);
    assign bus_hit = wr_fire && acc_region && acc_sel == ACC_IDX_W'(i);
    assign acc_val[i] = acc_bit_reg;
    assign ovf_flags[i] = ovf_bit_reg;

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        acc_bit_reg <= '0;
      end else if (hit_y) begin
        acc_bit_reg <= res_second; // RQ5 RQ22
      end else if (hit_x) begin
        acc_bit_reg <= res_first; // RQ6 RQ22
      end else if (bus_hit && address[ACC_HI_BIT]) begin
        acc_bit_reg[ACC_W-1:BUS_DW] <= wr_value[ACC_W-BUS_DW-1:0];
      end else if (bus_hit) begin
        acc_bit_reg[BUS_DW-1:0] <= wr_value;
      end
    end

    // a new overflow beats a write-one clear in the same cycle
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ovf_bit_reg <= 1'b0;
      end else if (hit_y ? ovf_second : (hit_x && ovf_first)) begin
        ovf_bit_reg <= 1'b1; // RQ14 RQ22
      end else if (wr_fire && address == STATUS_OFS && status_wr.ovf[i]) begin
        ovf_bit_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  issue_to_exec_a: assert property ( // RQ1
    state_reg == ST_ISSUE |=> state_reg == ST_FETCH ##1 exec)
    else $error("execute did not follow issue by two cycles");
  bad_opcode_a: assert property ( // RQ2
    wr_fire && address == OPCODE_OFS && !legal_op
    |=> !busy && illegal_reg)
    else $error("foreign opcode started or went unflagged");
  long_start_a: assert property ( // RQ3
    start && wr_value[OPC_VAR_MSB:OPC_VAR_LSB] == OPC_LONG
    |=> ##2 exec && long_mode)
    else $error("long form did not reach execute in long mode");
  shared_fetch_a: assert property ( // RQ4
    state_reg == ST_FETCH && !long_mode
    |-> mem_req_reg.data_rd && !mem_req_reg.data_pair_rd)
    else $error("shared form fetched more than one data word");
  coef_pair_a: assert property ( // RQ6
    mem_req_reg.coef_rd
    |-> mem_req_reg.coef_pair_addr == (mem_req_reg.coef_addr ^ PAIR_FLIP))
    else $error("low coefficient address is not the partner");
  data_pair_a: assert property ( // RQ8
    mem_req_reg.data_pair_rd
    |-> mem_req_reg.data_pair_addr == (mem_req_reg.data_addr ^ PAIR_FLIP))
    else $error("low data address is not the partner");
  both_written_a: assert property ( // RQ22
    exec && opt.acc_x != opt.acc_y
    |=> acc_val[$past(opt.acc_x)] == $past(res_first) &&
        acc_val[$past(opt.acc_y)] == $past(res_second))
    else $error("accumulators not written together");
  ovf_flag_set_a: assert property ( // RQ14
    exec && ovf_second |=> ovf_flags[$past(opt.acc_y)])
    else $error("overflow flag not set");
  sat_value_a: assert property ( // RQ15
    exec && ovf_first && mode_reg.saturation_mode && !mode_reg.m40 && !opt.forty
    |-> res_first == SAT_POS_32 || res_first == SAT_NEG_32)
    else $error("overflowed result not saturated at 32 bits");
  mode_kept_a: assert property ( // RQ16
    exec |=> $stable(mode_reg))
    else $error("mode changed by execution");
  repeat_loop_a: assert property ( // RQ18
    exec && exec_more |=> state_reg == ST_ISSUE)
    else $error("repeat did not reissue");
  coef_step_a: assert property ( // RQ19
    exec && cmode == MODE_INC |=> cptr_reg == $past(cptr_reg) + STEP_PAIR)
    else $error("coefficient pointer did not step by two");
  data_dec_a: assert property ( // RQ20
    exec && indirect && !long_mode && dmode == MODE_DEC
    |=> dptr_reg == $past(dptr_reg) - STEP_ONE)
    else $error("data pointer did not drop by one");

  shared_run_c: cover property (exec && !long_mode);
  long_run_c: cover property (exec && long_mode);
  repeat_run_c: cover property (exec && exec_more ##3 exec);
  overflow_c: cover property (exec && ovf_first && ovf_second);
endmodule
`default_nettype wire

// [dv/mem_model.sv]
// data and coefficient memory behind the datapath read buses
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import dual_mac_pkg::*;
(
  input wire logic clk,
  input wire mem_req_s mem_req,
  output mem_rsp_s mem_rsp
);
  function automatic logic [15:0] dw(input logic [15:0] a);
    return (a == 16'h0) ? 16'h8000 : a * 16'h9e37;
  endfunction
  function automatic logic [15:0] cw(input logic [15:0] a);
    return (a[15:1] == 15'h0) ? 16'h8000 : {a[7:0], a[15:8]} ^ 16'hc3a5;
  endfunction
  initial mem_rsp = '0;
  // =====
  // idle buses toggle so a stale word is never taken for data
  always @(posedge clk) begin
    mem_rsp <= ~mem_rsp;
    if (mem_req.data_rd) begin
      mem_rsp.d_read_bus <= dw(mem_req.data_pair_rd ?
        mem_req.data_pair_addr : mem_req.data_addr);
      if (mem_req.data_pair_rd)
        mem_rsp.c_read_bus <= dw(mem_req.data_addr);
    end
    if (mem_req.coef_rd) begin
      mem_rsp.b_read_bus <= cw(mem_req.coef_pair_addr);
      mem_rsp.b2_read_bus <= cw(mem_req.coef_addr);
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench of the dual multiply datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import dual_mac_pkg::*;
  logic clk = 0, sys_rst = 1, read = 0, write = 0, chk = 0;
  logic [7:0] address = '0;
  logic [31:0] writedata = '0, readdata, seed = 32'h7dbe, exp_r;
  logic waitrequest;
  mem_req_s mem_req, exp_m;
  mem_rsp_s mem_rsp;
  int n_mismatch = 0, n_tests = 0;
  logic [31:0] qr[$];
  mem_req_s qm[$];
  logic [39:0] acc[4];
  logic [3:0] ovf, byteenable = 4'hf;
  always #5 clk = ~clk;
  dual_mac_core DUT (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .mem_req(mem_req),
    .mem_rsp(mem_rsp));
  mem_model mem (.clk(clk), .mem_req(mem_req), .mem_rsp(mem_rsp));
  // =====
  // monitors take the oldest note whenever an answer shows
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && chk) begin
      exp_r = qr.pop_front();
      `CHK(readdata, exp_r)
    end
    if (!sys_rst && (mem_req.data_rd | mem_req.coef_rd) !== 1'b0) begin
      exp_m = qm.pop_front();
      `CHK(mem_req, exp_m)
    end
  end
  function automatic logic [31:0] lfsr();
    repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [15:0] dw(input logic [15:0] a);
    return (a == 16'h0) ? 16'h8000 : a * 16'h9e37;
  endfunction
  function automatic logic [15:0] cw(input logic [15:0] a);
    return (a[15:1] == 15'h0) ? 16'h8000 : {a[7:0], a[15:8]} ^ 16'hc3a5;
  endfunction
  function automatic logic [15:0] stp(input logic [15:0] p,
      input logic [1:0] md, input logic [15:0] s);
    return md == MODE_INC ? p + s : (md == MODE_DEC ? p - s : p);
  endfunction
  function automatic logic [40:0] mac(input logic [15:0] d, c,
      input logic [3:0] o, input logic [5:0] m);
    logic [16:0] a, b;
    logic signed [39:0] p;
    logic [40:0] r;
    logic ov;
    a = {~o[3] & m[5] & d[15], d};
    b = {~o[2] & m[5] & c[15], c};
    p = $signed(a) * $signed(b);
    if (m[0]) p = p <<< 1;
    if (m[0] & m[1] & a == OPND_MIN & b == OPND_MIN) p = PROD_SAT;
    r = {p[39], p};
    if (o[0]) begin
      r = r + RND_ADD;
      if (m[3] && p[15:0] == RND_HALF) r[16] = 1'b0;
      r[15:0] = '0;
    end
    ov = ~(m[2] | o[1]) && r[39:31] != {9{r[39]}};
    if (ov && m[4]) r[39:0] = r[39] ? SAT_NEG_32 : SAT_POS_32;
    return {ov, r[39:0]};
  endfunction
  task automatic finish_test();
    n_mismatch += qm.size() + qr.size();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // =====
  // bus master: holds the request until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    int i;
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= wd;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 100);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chk <= 1'b0;
    @(posedge clk);
    if (i >= 100) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    qr.push_back(e);
    chk <= 1'b1;
    xfer(1'b0, a, 32'h0, x);
  endtask
  task automatic chk_all(input logic [5:0] m, input logic [15:0] dp, cp,
      input logic ill);
    rd(STATUS_OFS, {24'h0, ovf, 2'b0, ill, 1'b0});
    for (int n = 0; n < 4; n++) begin
      rd(8'(32 + 8 * n), acc[n][31:0]);
      rd(8'(36 + 8 * n), {24'h0, acc[n][39:32]});
    end
    rd(CTRL_OFS, {26'h0, m});
    rd(DPTR_OFS, {16'h0, dp});
    rd(CPTR_OFS, {16'h0, cp});
  endtask
  task automatic run_one(input int k);
    logic [31:0] r, s, op, x;
    logic [15:0] dp, cp, ea, hi, lo;
    logic [5:0] m;
    logic [40:0] px, py;
    logic lng, ill;
    int rep, i;
    r = lfsr();
    s = lfsr();
    m = r[29:24];
    dp = s[15:0];
    cp = s[31:16];
    lng = r[12];
    op = {OPC_FIRST, r[23:16], 1'b0, lng, 4'h0, r[9:6], ~r[7:6], r[3:0]};
    ill = (k % 5 == 4);
    op[11] = ill;
    if (k == 2) begin
      m = m | 6'h23;
      {dp, cp, op[23:16], op[3:2]} = '0;
    end
    rep = int'(s[5:4]) % 3;
    wr(CTRL_OFS, {26'h0, m});
    wr(DPTR_OFS, {16'h0, dp});
    wr(CPTR_OFS, {16'h0, cp});
    wr(REPEAT_OFS, rep);
    for (i = 0; i <= rep && !ill; i++) begin
      ea = op[16] ? dp : {9'h0, op[23:17]};
      qm.push_back(mem_req_s'{ea, ea ^ PAIR_FLIP, 1'b1, lng, cp,
        cp ^ PAIR_FLIP, 1'b1});
      hi = dw(ea);
      lo = lng ? dw(ea ^ PAIR_FLIP) : hi;
      py = mac(hi, cw(cp), op[3:0], m);
      px = mac(lo, cw(cp ^ PAIR_FLIP), op[3:0], m);
      acc[op[5:4]] = py[39:0];
      acc[op[7:6]] = px[39:0];
      ovf[op[5:4]] |= py[40];
      ovf[op[7:6]] |= px[40];
      if (op[16]) dp = stp(dp, op[18:17], lng ? STEP_PAIR : STEP_ONE);
      cp = stp(cp, op[9:8], STEP_PAIR);
    end
    wr(OPCODE_OFS, op);
    i = 0;
    do begin
      xfer(1'b0, STATUS_OFS, 32'h0, x);
      i++;
    end while (x[0] !== 1'b0 && i < 50);
    // a run that never ends is a failure, not a pass
    if (x[0] !== 1'b0) begin
      n_mismatch++;
      finish_test();
    end
    chk_all(m, dp, cp, ill);
    wr(STATUS_OFS, 32'hf2);
    ovf = '0;
  endtask
  initial begin
    #900000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    ovf = '0;
    for (int n = 0; n < 4; n++) acc[n] = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_all(6'h20, 16'h0, 16'h0, 1'b0);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0);
    rd(REPEAT_OFS, 32'h0);
    // a write with its only live lane disabled must leave the mode alone
    byteenable <= 4'he;
    wr(CTRL_OFS, 32'h0);
    byteenable <= 4'hf;
    rd(CTRL_OFS, 32'h20);
    for (int k = 0; k < 16; k++) run_one(k);
    finish_test();
  end
endmodule
`default_nettype wire
